//--- uart_flow_ctrl_and_interrupts.sv
// UART with clear-to-send flow control, 9-bit multidrop framing,
// transmit and receive interrupts and overrun protection.
// Assumes a synchronous register port and asynchronous rxd/cts_n pins.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_flow_ctrl_and_interrupts (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Serial pins
	input wire logic rxd,
	input wire logic cts_n,
	output logic txd,
	// Interrupt
	output logic irq
);
	// ==========================================================
	// Registers and synchronisers
	logic [7:0] ctrl0, ctrl1, mask, match_addr, int_st;
	logic [15:0] brg;
	logic [1:0] rx_sync, cts_sync;
	logic rx_s, rx_prev, cts_s;
	logic wr_tx, rd_rx;
	logic [4:0] ev;

	assign wr_tx = wr && addr == `A_DATA;
	assign rd_rx = rd && addr == `A_DATA;
	assign rx_s = rx_sync[1];
	assign cts_s = cts_sync[1];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sync <= 2'h3;
			cts_sync <= 2'h3;
			rx_prev <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[0], rxd};
			cts_sync <= {cts_sync[0], cts_n};
			rx_prev <= rx_s;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl0 <= `CTRL0_RST;
			ctrl1 <= `CTRL1_RST;
			brg <= `BRG_RST;
			mask <= `MASK_RST;
			match_addr <= `ADDR_RST;
		end else if (wr) begin
			case (addr)
				`A_CTRL0: ctrl0 <= wdata;
				`A_CTRL1: ctrl1 <= wdata;
				`A_BRG_LO: brg[7:0] <= wdata;
				`A_BRG_HI: brg[15:8] <= wdata;
				`A_MASK: mask <= wdata;
				`A_ADDR: match_addr <= wdata;
				default: ;
			endcase
		end
	end

	// Bit period never below two clocks; at that minimum the half-bit count is zero
	logic [15:0] period, half;
	logic ninth_en;
	assign period = (brg < 16'h0002) ? 16'h0001 : brg - 16'h0001;
	assign half = {1'b0, period[15:1]};
	assign ninth_en = ctrl0[`C0_PEN] | ctrl0[`C0_MDE];

	// ==========================================================
	// Transmitter
	uart_pkg::seq_state_t tx_state;
	logic [15:0] tx_cnt;
	logic [3:0] tx_bit;
	logic [7:0] tx_shift, hold;
	logic tx_ninth, hold_full, thr_empty, tx_tick, tx_go, thr_set;

	assign tx_tick = tx_cnt == 16'h0000;
	assign tx_go = tx_state == uart_pkg::S_IDLE && hold_full &&
		ctrl0[`C0_TXEN] && (!ctrl0[`C0_CTS_FLOW_ENABLE] || !cts_s);
	assign thr_set = tx_state == uart_pkg::S_START && tx_tick &&
		!hold_full && !wr_tx;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_state <= uart_pkg::S_IDLE;
			tx_cnt <= 16'h0000;
			tx_bit <= 4'h0;
			tx_shift <= 8'h00;
			tx_ninth <= 1'b0;
			txd <= 1'b1;
		end else begin
			tx_cnt <= tx_tick ? period : tx_cnt - 16'h0001;
			case (tx_state)
				uart_pkg::S_IDLE: begin
					txd <= 1'b1;
					tx_cnt <= period;
					if (tx_go) begin
						tx_shift <= hold;
						tx_ninth <= ctrl0[`C0_MDE] ? ctrl1[`C1_NINTH] :
							^hold ^ ctrl0[`C0_PODD];
						txd <= 1'b0;
						tx_state <= uart_pkg::S_START;
					end
				end
				uart_pkg::S_START: if (tx_tick) begin
					txd <= tx_shift[0];
					tx_bit <= 4'h0;
					tx_state <= uart_pkg::S_DATA;
				end
				uart_pkg::S_DATA: if (tx_tick) begin
					tx_bit <= tx_bit + 4'h1;
					tx_shift <= {1'b0, tx_shift[7:1]};
					txd <= tx_shift[1];
					if (tx_bit == `DATA_BITS) begin
						txd <= ninth_en ? tx_ninth : 1'b1;
						tx_bit <= 4'h0;
						tx_state <= ninth_en ? uart_pkg::S_NINTH :
							uart_pkg::S_STOP;
					end
				end
				uart_pkg::S_NINTH: if (tx_tick) begin
					txd <= 1'b1;
					tx_state <= uart_pkg::S_STOP;
				end
				uart_pkg::S_STOP: if (tx_tick) begin
					// Clear-to-send is looked at only in idle, before the start bit
					if (ctrl0[`C0_STOP2] && tx_bit == 4'h0)
						tx_bit <= 4'h1;
					else
						tx_state <= uart_pkg::S_IDLE;
				end
				default: tx_state <= uart_pkg::S_IDLE;
			endcase
		end
	end

	// A write wins over the empty event: it refills the holding register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold <= 8'h00;
			hold_full <= 1'b0;
			thr_empty <= 1'b1;
		end else begin
			if (wr_tx) begin
				hold <= wdata;
				hold_full <= 1'b1;
				thr_empty <= 1'b0;
			end else begin
				if (tx_go)
					hold_full <= 1'b0;
				if (thr_set)
					thr_empty <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Receiver
	uart_pkg::seq_state_t rx_state;
	logic [15:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_ninth, rx_tick, done, fe, brk, pe;

	assign rx_tick = rx_cnt == 16'h0000;
	assign done = rx_state == uart_pkg::S_STOP && rx_tick;
	assign fe = !rx_s;
	assign brk = !rx_s && rx_shift == 8'h00 && !(ninth_en && rx_ninth);
	assign pe = ctrl0[`C0_PEN] && !ctrl0[`C0_MDE] &&
		(rx_ninth != (^rx_shift ^ ctrl0[`C0_PODD]));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_state <= uart_pkg::S_IDLE;
			rx_cnt <= 16'h0000;
			rx_bit <= 4'h0;
			rx_shift <= 8'h00;
			rx_ninth <= 1'b0;
		end else begin
			rx_cnt <= rx_tick ? period : rx_cnt - 16'h0001;
			case (rx_state)
				uart_pkg::S_IDLE: begin
					rx_cnt <= half;
					// Edge start keeps a held break from restarting frames
					if (ctrl0[`C0_RXEN] && rx_prev && !rx_s)
						rx_state <= uart_pkg::S_START;
				end
				uart_pkg::S_START: if (rx_tick) begin
					rx_bit <= 4'h0;
					rx_state <= rx_s ? uart_pkg::S_IDLE : uart_pkg::S_DATA;
				end
				uart_pkg::S_DATA: if (rx_tick) begin
					rx_shift <= {rx_s, rx_shift[7:1]};
					rx_bit <= rx_bit + 4'h1;
					rx_ninth <= 1'b0;
					if (rx_bit == `DATA_BITS)
						rx_state <= ninth_en ? uart_pkg::S_NINTH :
							uart_pkg::S_STOP;
				end
				uart_pkg::S_NINTH: if (rx_tick) begin
					rx_ninth <= rx_s;
					rx_state <= uart_pkg::S_STOP;
				end
				uart_pkg::S_STOP: if (rx_tick)
					rx_state <= uart_pkg::S_IDLE;
				default: rx_state <= uart_pkg::S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receive holding, overrun and multidrop filter
	logic [7:0] rx_data, pend_data;
	logic rx_data_available_flag, st_ovr, st_brk, st_fe, st_pe, st_ninth;
	logic pend, pend_brk, pend_fe, pend_pe, pend_ninth, pend_want;
	logic last_match, is_addr, want, accept, show, to_pend;

	assign is_addr = ctrl0[`C0_MDE] && rx_ninth;
	always_comb begin
		want = 1'b1;
		if (ctrl0[`C0_MDE]) begin
			case (ctrl1[`C1_SEL_HI:`C1_SEL_LO])
				2'h0: want = 1'b1;
				2'h1: want = is_addr;
				2'h2: want = !is_addr && last_match;
				2'h3: want = is_addr ? rx_shift == match_addr : last_match;
				default: want = 1'b1;
			endcase
		end
	end
	assign show = rd_rx && pend;
	assign to_pend = done && ((rx_data_available_flag && !rd_rx) || show);
	assign accept = done && !to_pend;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_match <= 1'b0;
		end else if (done && is_addr) begin
			last_match <= rx_shift == match_addr;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_data <= 8'h00;
			{rx_data_available_flag, st_ovr, st_brk, st_fe, st_pe, st_ninth} <= 6'h00;
			pend_data <= 8'h00;
			{pend, pend_brk, pend_fe, pend_pe, pend_ninth} <= 5'h00;
			pend_want <= 1'b0;
		end else begin
			if (rd_rx) begin
				{rx_data_available_flag, st_ovr, st_brk, st_fe, st_pe} <= 5'h00;
				if (pend) begin
					rx_data <= pend_data;
					st_ninth <= pend_ninth;
					rx_data_available_flag <= 1'b1;
					st_ovr <= 1'b1;
					st_brk <= pend_brk;
					st_fe <= pend_fe;
					st_pe <= pend_pe;
					pend <= 1'b0;
				end
			end
			// A second overrun while one is pending is dropped
			if (to_pend && (!pend || rd_rx)) begin
				pend <= 1'b1;
				pend_data <= rx_shift;
				pend_ninth <= rx_ninth;
				pend_brk <= brk;
				pend_fe <= fe;
				pend_pe <= pe;
				pend_want <= want;
			end
			if (accept) begin
				rx_data <= rx_shift;
				st_ninth <= rx_ninth;
				rx_data_available_flag <= 1'b1;
				st_brk <= brk;
				st_fe <= fe;
				st_pe <= pe;
			end
		end
	end

	// ==========================================================
	// Interrupt status; a new event wins over a write-one clear
	assign ev[`I_RXD] = !ctrl0[`C0_RXIDIS] &&
		((accept && want) || (show && pend_want));
	assign ev[`I_BRK] = (accept && brk) || (show && pend_brk);
	assign ev[`I_OVR] = show;
	assign ev[`I_FE] = (accept && fe) || (show && pend_fe);
	assign ev[`I_TX] = thr_set;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			int_st <= 8'h00;
		else if (wr && addr == `A_INT)
			int_st <= (int_st & ~wdata) | {3'h0, ev};
		else
			int_st <= int_st | {3'h0, ev};
	end

	assign irq = |(int_st & mask);

	// ==========================================================
	// Read port: data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (!rd) begin
			rdata <= 8'h00;
		end else begin
			case (addr)
				`A_DATA: rdata <= rx_data;
				`A_STAT0: rdata <= {rx_data_available_flag, st_pe, st_ovr, st_fe, st_brk,
					thr_empty, tx_state == uart_pkg::S_IDLE, !cts_s};
				`A_CTRL0: rdata <= ctrl0;
				`A_CTRL1: rdata <= ctrl1;
				`A_BRG_LO: rdata <= brg[7:0];
				`A_BRG_HI: rdata <= brg[15:8];
				`A_INT: rdata <= int_st;
				`A_MASK: rdata <= mask;
				`A_ADDR: rdata <= match_addr;
				`A_STAT1: rdata <= {7'h00, st_ninth};
				default: rdata <= 8'h00;
			endcase
		end
	end
endmodule : uart_flow_ctrl_and_interrupts

//--- uart_cfg.svh
// Offsets, field positions, reset values and timing counts of the UART.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// Register addresses
`define A_DATA 4'h0
`define A_STAT0 4'h1
`define A_CTRL0 4'h2
`define A_CTRL1 4'h3
`define A_BRG_LO 4'h4
`define A_BRG_HI 4'h5
`define A_INT 4'h6
`define A_MASK 4'h7
`define A_ADDR 4'h8
`define A_STAT1 4'h9
// Control 0 bits
`define C0_TXEN 0
`define C0_RXEN 1
`define C0_CTS_FLOW_ENABLE 2
`define C0_PEN 3
`define C0_PODD 4
`define C0_STOP2 5
`define C0_MDE 6
`define C0_RXIDIS 7
// Control 1 fields
`define C1_SEL_LO 0
`define C1_SEL_HI 1
`define C1_NINTH 2
// Interrupt status bits
`define I_RXD 0
`define I_BRK 1
`define I_OVR 2
`define I_FE 3
`define I_TX 4
// Reset values and the last data-bit index
`define CTRL0_RST 8'h00
`define CTRL1_RST 8'h00
`define BRG_RST 16'h00AE
`define MASK_RST 8'h00
`define ADDR_RST 8'h00
`define DATA_BITS 4'h7
`endif

//--- uart_pkg.sv
// Types of the UART transmitter and receiver sequencers.
// Assumes nothing beyond a SystemVerilog compiler.
package uart_pkg;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_START = 5'h02,
		S_DATA = 5'h04,
		S_NINTH = 5'h08,
		S_STOP = 5'h10
	} seq_state_t;
endpackage : uart_pkg

//--- uart_flow_ctrl_and_interrupts_checker.sv
// Checker of the UART ports: bus, interrupt and serial framing.
// Assumes the bench sets a divisor of 4 clocks a bit.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_chk (
	// Clock and reset
	input logic clk,
	input logic arst_n,
	// Register port
	input logic [3:0] addr,
	input logic [7:0] wdata,
	input logic wr,
	input logic rd,
	input logic [7:0] rdata,
	// Pins
	input logic rxd,
	input logic cts_n,
	input logic txd,
	input logic irq
);
	logic [7:0] mask;
	logic cts_flow_enable;
	logic [7:0] hi_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ====
	// Shadows; a long high run means no character is on the line
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask <= 8'h00;
			cts_flow_enable <= 1'b0;
		end else if (wr && addr == `A_MASK)
			mask <= wdata;
		else if (wr && addr == `A_CTRL0)
			cts_flow_enable <= wdata[`C0_CTS_FLOW_ENABLE];
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			hi_cnt <= 8'h00;
		else if (!txd)
			hi_cnt <= 8'h00;
		else if (hi_cnt != 8'hFF)
			hi_cnt <= hi_cnt + 8'h01;
	end
	rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read cycle");
	unmapped_read_a: assert property ($past(rd && addr == 4'hF) |->
		rdata == 8'h00)
		else $error("unmapped read not zero");
	mask_gate_a: assert property (mask == 8'h00 |-> !irq)
		else $error("interrupt with mask clear");
	reset_idle_a: assert property ($rose(arst_n) |-> txd && !irq)
		else $error("not idle after reset");
	tx_clear_a: assert property ($past(wr && addr == `A_DATA, 3) &&
		$past(rd && addr == `A_STAT0) |-> !rdata[2])
		else $error("holding flag not cleared");
	start_len_a: assert property ($fell(txd) |-> !txd [*4])
		else $error("low bit too short");
	stop_len_a: assert property ($rose(txd) |-> txd [*4])
		else $error("high bit too short");
	cts_hold_a: assert property (cts_flow_enable && hi_cnt > 8'h32 &&
		$past(cts_n) && $past(cts_n, 2) && $past(cts_n, 3) &&
		$past(cts_n, 4) |-> txd)
		else $error("start without clear to send");
endmodule : uart_chk
bind uart_flow_ctrl_and_interrupts uart_chk chk_u (.clk(clk), .arst_n(arst_n),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
	.cts_n(cts_n), .txd(txd), .irq(irq));

//--- uart_far_end.sv
// Far-end UART on the shared line, four clocks a bit.
// Assumes txd changes only at rising clock edges.
`timescale 1ns/1ps
module uart_far_end (
	// Clock
	input logic clk,
	// Serial line
	input logic txd,
	output logic rxd,
	output logic cts_n
);
	logic [7:0] got;
	logic got9;
	logic gotstop;
	logic nine = 1'b0;
	int cnt = 0;
	initial rxd = 1'b1;
	initial cts_n = 1'b0;
	// ====
	// Sending side; the line is pulled high when idle
	task hold_cts(input logic x);
		@(posedge clk) cts_n <= x;
	endtask : hold_cts
	task put(input logic x);
		rxd <= x;
		repeat (4) @(posedge clk);
	endtask : put
	task send(input logic [7:0] d, input logic b9, input logic stp);
		@(posedge clk);
		put(1'b0);
		for (int i = 0; i < 8; i++)
			put(d[i]);
		if (nine)
			put(b9);
		put(stp);
		put(1'b1);
	endtask : send
	// Receiving side samples mid-bit
	always begin
		@(negedge txd);
		repeat (2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (4) @(posedge clk);
			got[i] = txd;
		end
		if (nine) begin
			repeat (4) @(posedge clk);
			got9 = txd;
		end
		repeat (4) @(posedge clk);
		gotstop = txd;
		cnt++;
	end
endmodule : uart_far_end

//--- uart_flow_ctrl_and_interrupts_tb.sv
// Bench: register tasks against the UART and a far-end model.
// Assumes a divisor of 4, so a frame is about forty clocks.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_flow_ctrl_and_interrupts_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic rxd;
	logic cts_n;
	logic txd;
	logic irq;
	logic [7:0] v;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	uart_flow_ctrl_and_interrupts dut_u (.clk(clk), .arst_n(arst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rxd(rxd), .cts_n(cts_n), .txd(txd), .irq(irq));
	uart_far_end far_u (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
	// ====
	// Tasks
	task check(input string what, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		// Data stand only in the cycle after the strobe; take them at its end
		@(posedge clk);
		v = rdata;
	endtask : rreg
	task wait_cnt(input int n);
		for (int i = 0; i < 400 && far_u.cnt < n; i++)
			@(posedge clk);
		check("frames", 8'(far_u.cnt), 8'(n));
	endtask : wait_cnt
	task finish_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			finish_test;
		end
	end
	// ====
	// Scenarios
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		far_u.hold_cts(1'b1);
		wreg(`A_BRG_LO, 8'h04);
		wreg(`A_BRG_HI, 8'h00);
		wreg(`A_MASK, 8'h1F);
		wreg(`A_CTRL0, 8'h03);
		rreg(4'hF);
		check("unmapped", v, 8'h00);
		wreg(`A_DATA, 8'hA5);
		rreg(`A_STAT0);
		check("empty", v & 8'h04, 8'h00);
		repeat (4) @(posedge clk);
		rreg(`A_STAT0);
		check("empty", v & 8'h04, 8'h04);
		check("irq", 8'(irq), 8'h01);
		wait_cnt(1);
		check("tx byte", far_u.got, 8'hA5);
		check("stop", 8'(far_u.gotstop), 8'h01);
		wreg(`A_INT, 8'hFF);
		wreg(`A_CTRL0, 8'h07);
		wreg(`A_DATA, 8'h3C);
		repeat (80) @(posedge clk);
		check("held", 8'(far_u.cnt), 8'h01);
		far_u.hold_cts(1'b0);
		wait_cnt(2);
		check("tx byte", far_u.got, 8'h3C);
		wreg(`A_DATA, 8'hF0);
		repeat (4) @(posedge clk);
		far_u.hold_cts(1'b1);
		wait_cnt(3);
		check("tx byte", far_u.got, 8'hF0);
		far_u.hold_cts(1'b0);
		far_u.nine = 1'b1;
		wreg(`A_CTRL1, 8'h04);
		wreg(`A_CTRL0, 8'h43);
		wreg(`A_DATA, 8'h81);
		wait_cnt(4);
		check("tx byte", far_u.got, 8'h81);
		check("ninth", 8'(far_u.got9), 8'h01);
		wreg(`A_CTRL1, 8'h01);
		wreg(`A_INT, 8'hFF);
		far_u.send(8'h12, 1'b0, 1'b1);
		rreg(`A_INT);
		check("rx int", v & 8'h01, 8'h00);
		rreg(`A_DATA);
		far_u.send(8'h34, 1'b1, 1'b1);
		rreg(`A_INT);
		check("rx int", v & 8'h01, 8'h01);
		rreg(`A_DATA);
		check("rx byte", v, 8'h34);
		wreg(`A_ADDR, 8'h5C);
		wreg(`A_CTRL1, 8'h02);
		wreg(`A_INT, 8'hFF);
		far_u.send(8'h5C, 1'b1, 1'b1);
		rreg(`A_DATA);
		rreg(`A_INT);
		check("rx int", v & 8'h01, 8'h00);
		far_u.send(8'h21, 1'b0, 1'b1);
		rreg(`A_INT);
		check("rx int", v & 8'h01, 8'h01);
		rreg(`A_DATA);
		check("rx byte", v, 8'h21);
		far_u.send(8'h77, 1'b1, 1'b1);
		rreg(`A_DATA);
		wreg(`A_INT, 8'hFF);
		far_u.send(8'h22, 1'b0, 1'b1);
		rreg(`A_INT);
		check("rx int", v & 8'h01, 8'h00);
		rreg(`A_DATA);
		check("rx byte", v, 8'h22);
		far_u.nine = 1'b0;
		wreg(`A_CTRL0, 8'h83);
		wreg(`A_INT, 8'hFF);
		far_u.send(8'h56, 1'b0, 1'b1);
		rreg(`A_INT);
		check("rx int", v & 8'h01, 8'h00);
		rreg(`A_DATA);
		check("rx byte", v, 8'h56);
		wreg(`A_CTRL0, 8'h03);
		wreg(`A_INT, 8'hFF);
		fork
			far_u.send(8'h5A, 1'b0, 1'b1);
			begin
				repeat (30) @(posedge clk);
				check("irq", 8'(irq), 8'h00);
			end
		join
		check("irq", 8'(irq), 8'h01);
		far_u.send(8'h00, 1'b0, 1'b0);
		rreg(`A_STAT0);
		check("hidden", v & 8'hB8, 8'h80);
		rreg(`A_DATA);
		check("held byte", v, 8'h5A);
		rreg(`A_STAT0);
		check("shown", v & 8'hB8, 8'hB8);
		rreg(`A_INT);
		check("rx int", v & 8'h0E, 8'h0E);
		rreg(`A_DATA);
		check("break byte", v, 8'h00);
		far_u.send(8'h7E, 1'b0, 1'b0);
		rreg(`A_STAT0);
		check("framing", v & 8'h18, 8'h10);
		check("irq", 8'(irq), 8'h01);
		wreg(`A_MASK, 8'h00);
		@(posedge clk);
		check("irq", 8'(irq), 8'h00);
		finish_test;
	end
endmodule : uart_flow_ctrl_and_interrupts_tb
